// [pmc_pkg.sv]
// power-mode controller package: register map, field positions, reset values
// assumes a 32-bit classic wishbone slave port, one register per aligned word
package pmc_pkg;
  // register indices (printed offsets); byte address is four times the index
  localparam logic [7:0] PMC_PWR_CTRL_IDX = 8'h87;
  localparam logic [7:0] PMC_CLK_CTRL_IDX = 8'hf9;
  localparam logic [7:0] PMC_STATUS_IDX = 8'hfa;
  // power_control fields
  localparam int PMC_IDLE_BIT = 0;
  localparam int PMC_PD_BIT = 1;
  localparam int PMC_UART1_TX_CLOCK_SELECT_BIT = 2;
  localparam int PMC_UART1_RX_CLOCK_SELECT_BIT = 3;
  localparam int PMC_COLD_BIT = 4;
  localparam int PMC_UART1_BAUD_DOUBLE_BIT = 6;
  localparam int PMC_UART0_BAUD_DOUBLE_BIT = 7;
  localparam logic [7:0] PMC_PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] PMC_PWR_CTRL_WMASK = 8'hcf;
  // clock_control_reg fields
  localparam int PMC_DIV_LSB = 0;
  localparam int PMC_AUTO_BIT = 3;
  localparam int PMC_DBG_BIT = 4;
  localparam logic [7:0] PMC_CLK_CTRL_RST = 8'h10;
  localparam logic [7:0] PMC_CLK_CTRL_WMASK = 8'h1f;
  // cycles of core clock a supervisor reset holds the core after idle
  localparam int PMC_RESTART_CYCLES = 3;
  typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_PDOWN, PMC_RESTART} pmc_mode_t;
endpackage

// [pmc_power_mode.sv]
// power-mode controller: idle, power-down, core clock prescaler, power register
// assumes the core, peripherals and supervisor share clk_i (the oscillator)
//
// Function
// - idle gates the core and watchdog clocks
// - peripheral interrupt or supervisor reset ends idle
// - port outputs hold in idle and power-down
// - setting idle_request bit 0 enters idle
// - core state retained through idle
// - enabled interrupt clears idle_request in hardware
// - supervisor reset ends idle, restart after three
// - power-down stops oscillator, core, peripheral clocks
// - setting powerdown_request bit 1 enters power-down
// - only supervisor resets end power-down, never watchdog
// - watchdog stopped in idle, other resets live
// - bus pins rest idle levels in low power
// - prescaler divides oscillator by one to 2048
// - division applies only to core and watchdog
// - auto restore forces divider to zero on interrupt
// - cold start flag set by power-on or by a software write of bit 4
// - bits 7,6 are uart baud doubling
// - bits 3,2 uart1 clock selects, bit5 reserved
// - divider codes select 1,2,4,...,32,1024,2048
// - new divider applies immediately on write
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module pmc_power_mode
  import pmc_pkg::*;
#(
  parameter int DIV_W = 11
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // supervisor and events
  input wire logic power_on_reset_i,
  input wire logic sup_reset_i,
  input wire logic watchdog_reset_i,
  input wire logic irq_any_i,
  // core-side bus and ports
  input wire logic [23:0] port_out_i,
  input wire logic ale_i,
  input wire logic program_fetch_strobe_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] muxed_addr_data_low_i,
  input wire logic [7:0] addr_high_byte_i,
  // clock enables and controls
  output logic osc_enable_o,
  output logic core_clk_en_o,
  output logic peripheral_clk_en_o,
  output logic watchdog_clk_en_o,
  output logic core_reset_o,
  output logic [23:0] port_out_o,
  output logic ale_o,
  output logic program_fetch_strobe_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] muxed_addr_data_low_o,
  output logic [7:0] addr_high_byte_o,
  output logic uart0_baud_double_o,
  output logic uart1_baud_double_o,
  output logic uart1_rx_clock_select_o,
  output logic uart1_tx_clock_select_o,
  output logic debug_cmp_enable_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic por_s;
  logic sup_s;
  logic irq_s;

  // two stages before any logic reads the asynchronous inputs
  always_ff @(posedge clk_i)
  begin
    sync1 <= {power_on_reset_i, sup_reset_i, irq_any_i};
    sync2 <= sync1;
  end
  // a power-on reset counts as a supervisor reset as well
  assign por_s = sync2[2];
  assign sup_s = sync2[1] | sync2[2];
  assign irq_s = sync2[0];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic hit_pwr;
  logic hit_clk;
  logic hit_sts;
  logic wr_pwr;
  logic wr_clk;
  logic [7:0] power_control;
  logic [7:0] clock_control_reg;
  pmc_mode_t mode;
  logic [1:0] restart_cnt;

  function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wd, input logic [7:0] m);
    merge = (cur & ~m) | (wd & m);
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign hit_pwr = wb_adr_i[11:2] == {2'h0, PMC_PWR_CTRL_IDX};
  assign hit_clk = wb_adr_i[11:2] == {2'h0, PMC_CLK_CTRL_IDX};
  assign hit_sts = wb_adr_i[11:2] == {2'h0, PMC_STATUS_IDX};
  assign wr_pwr = req & wb_we_i & wb_sel_i[0] & hit_pwr;
  assign wr_clk = req & wb_we_i & wb_sel_i[0] & hit_clk;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= req & (hit_pwr | hit_clk | hit_sts);
      wb_err_o <= req & ~(hit_pwr | hit_clk | hit_sts);
      if (req & ~wb_we_i)
      begin
        if (hit_pwr)
          wb_dat_o <= {24'h0, power_control};
        else if (hit_clk)
          wb_dat_o <= {24'h0, clock_control_reg};
        else if (hit_sts)
          wb_dat_o <= {30'h0, mode};
        else
          wb_dat_o <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // power_control register
  // ----------------------------------------------------------------
  logic cold_seen;

  // cold start flag: hardware set wins over software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cold_seen <= 1'b0;
    else
      cold_seen <= por_s;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      power_control <= PMC_PWR_CTRL_RST;
    else if (sup_s)
    begin
      // supervisor reset keeps the cold flag; power-on sets it
      power_control <= PMC_PWR_CTRL_RST;
      power_control[PMC_COLD_BIT] <= power_control[PMC_COLD_BIT] | por_s;
    end
    else
    begin
      if (wr_pwr)
        power_control <= merge(power_control, wb_dat_i[7:0], PMC_PWR_CTRL_WMASK | 8'h10);
      if (cold_seen)
        power_control[PMC_COLD_BIT] <= 1'b1;
      if (irq_s & (mode == PMC_IDLE))
        power_control[PMC_IDLE_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clock_control_reg and prescaler
  // ----------------------------------------------------------------
  logic [2:0] div_sel;
  logic [DIV_W-1:0] div_cnt;
  logic div_tick;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clock_control_reg <= PMC_CLK_CTRL_RST;
    else if (irq_s & clock_control_reg[PMC_AUTO_BIT])
      clock_control_reg[PMC_DIV_LSB +: 3] <= 3'h0;
    else if (wr_clk)
      clock_control_reg <= merge(clock_control_reg, wb_dat_i[7:0], PMC_CLK_CTRL_WMASK);
  end

  assign div_sel = clock_control_reg[PMC_DIV_LSB +: 3];

  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
    unique case (sel)
      3'h0: div_mask = DIV_W'(0);
      3'h1: div_mask = DIV_W'(1);
      3'h2: div_mask = DIV_W'(3);
      3'h3: div_mask = DIV_W'(7);
      3'h4: div_mask = DIV_W'(15);
      3'h5: div_mask = DIV_W'(31);
      3'h6: div_mask = DIV_W'(1023);
      3'h7: div_mask = DIV_W'(2047);
    endcase
  endfunction

  // free-running counter: a new divider acts from the next edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + DIV_W'(1);
  end
  assign div_tick = (div_cnt & div_mask(div_sel)) == '0;

  // ----------------------------------------------------------------
  // mode machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode <= PMC_RUN;
      restart_cnt <= 2'h0;
    end
    else
    begin
      unique case (mode)
        PMC_RUN:
          if (power_control[PMC_PD_BIT])
            mode <= PMC_PDOWN;
          else if (power_control[PMC_IDLE_BIT])
            mode <= PMC_IDLE;
        PMC_IDLE:
          if (sup_s)
          begin
            mode <= PMC_RESTART;
            restart_cnt <= 2'h0;
          end
          else if (power_control[PMC_PD_BIT])
            mode <= PMC_PDOWN;
          else if (!power_control[PMC_IDLE_BIT])
            mode <= PMC_RUN;
        // only the supervisor ends power-down; the watchdog input is not used
        PMC_PDOWN:
          if (sup_s)
          begin
            mode <= PMC_RESTART;
            restart_cnt <= 2'h0;
          end
        // restart counts core clock ticks, so it stretches with the divider
        PMC_RESTART:
          if (sup_s)
            restart_cnt <= 2'h0;
          else if (div_tick)
          begin
            if (restart_cnt == 2'(PMC_RESTART_CYCLES - 1))
              mode <= PMC_RUN;
            restart_cnt <= restart_cnt + 2'h1;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic low_power;
  logic [23:0] port_hold;
  assign low_power = (mode == PMC_IDLE) | (mode == PMC_PDOWN);

  // port values are captured while running and frozen in low power
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_hold <= 24'hffffff;
    else if (!low_power)
      port_hold <= port_out_i;
  end

  assign osc_enable_o = mode != PMC_PDOWN;
  assign core_clk_en_o = (mode == PMC_RUN) & div_tick;
  assign watchdog_clk_en_o = (mode == PMC_RUN) & div_tick;
  assign peripheral_clk_en_o = mode != PMC_PDOWN;
  assign core_reset_o = mode == PMC_RESTART;
  assign port_out_o = low_power ? port_hold : port_out_i;
  assign ale_o = low_power ? 1'b0 : ale_i;
  assign program_fetch_strobe_n_o = low_power | program_fetch_strobe_n_i;
  assign rd_n_o = low_power | rd_n_i;
  assign wr_n_o = low_power | wr_n_i;
  assign muxed_addr_data_low_o = low_power ? 8'hff : muxed_addr_data_low_i;
  assign addr_high_byte_o = low_power ? 8'hff : addr_high_byte_i;
  assign uart0_baud_double_o = power_control[PMC_UART0_BAUD_DOUBLE_BIT];
  assign uart1_baud_double_o = power_control[PMC_UART1_BAUD_DOUBLE_BIT];
  assign uart1_rx_clock_select_o = power_control[PMC_UART1_RX_CLOCK_SELECT_BIT];
  assign uart1_tx_clock_select_o = power_control[PMC_UART1_TX_CLOCK_SELECT_BIT];
  assign debug_cmp_enable_o = clock_control_reg[PMC_DBG_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  idle_core_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == PMC_IDLE) |-> !core_clk_en_o && peripheral_clk_en_o) else $error("idle clocks wrong");
  pd_all_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == PMC_PDOWN) |-> !osc_enable_o && !peripheral_clk_en_o) else $error("power-down clocks run");
  idle_enter_a: assert property (@(posedge clk_i) disable iff (rst_i || sup_s)
    (mode == PMC_RUN && power_control[0] && !power_control[1]) |=> mode == PMC_IDLE) else $error("idle not entered");
  both_req_pd_a: assert property (@(posedge clk_i) disable iff (rst_i || sup_s)
    (mode == PMC_RUN && power_control[1]) |=> mode == PMC_PDOWN) else $error("power-down not entered");
  irq_clear_idle_a: assert property (@(posedge clk_i) disable iff (rst_i || sup_s)
    (mode == PMC_IDLE && irq_s) |=> !power_control[0] ##1 mode == PMC_RUN) else $error("idle not ended");
  pd_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == PMC_PDOWN && !sup_s) |=> mode == PMC_PDOWN) else $error("power-down left");
  bus_rest_a: assert property (@(posedge clk_i) disable iff (rst_i)
    low_power |-> !ale_o && rd_n_o && wr_n_o && muxed_addr_data_low_o == 8'hff) else $error("bus not at rest");
  auto_restore_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_s && clock_control_reg[3]) |=> clock_control_reg[2:0] == 3'h0) else $error("divider not restored");
  wdog_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    low_power |-> !watchdog_clk_en_o) else $error("watchdog runs in low power");
  port_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_power && $past(low_power)) |-> $stable(port_out_o)) else $error("port changed");

  // ----------------------------------------------------------------
  // restart, register and bus checks
  // ----------------------------------------------------------------
  sup_idle_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((mode == PMC_IDLE) && sup_s) |=> core_reset_o && !power_control[PMC_IDLE_BIT] && !power_control[PMC_PD_BIT])
    else $error("supervisor reset did not end idle");
  restart_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (core_reset_o && !sup_s && div_tick && (restart_cnt == 2'(PMC_RESTART_CYCLES - 1))) |=> (mode == PMC_RUN))
    else $error("restart too long");
  restart_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (core_reset_o && !div_tick) |=> core_reset_o)
    else $error("restart ended without a core tick");
  cold_por_a: assert property (@(posedge clk_i) disable iff (rst_i)
    por_s |=> power_control[PMC_COLD_BIT])
    else $error("cold flag not set by power-on");
  cold_warm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sup_s && !por_s && !cold_seen && !power_control[PMC_COLD_BIT]) |=> !power_control[PMC_COLD_BIT])
    else $error("cold flag set by warm reset");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    power_control[5] == 1'b0)
    else $error("reserved bit set");
  uart_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_pwr && !sup_s) |=> (uart0_baud_double_o == $past(wb_dat_i[PMC_UART0_BAUD_DOUBLE_BIT])) &&
      (uart1_baud_double_o == $past(wb_dat_i[PMC_UART1_BAUD_DOUBLE_BIT])))
    else $error("baud doubling bits not written");
  uart_clk_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_pwr && !sup_s) |=> (uart1_rx_clock_select_o == $past(wb_dat_i[PMC_UART1_RX_CLOCK_SELECT_BIT])) &&
      (uart1_tx_clock_select_o == $past(wb_dat_i[PMC_UART1_TX_CLOCK_SELECT_BIT])))
    else $error("uart clock selects not written");
  div_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_clk && !(irq_s && clock_control_reg[PMC_AUTO_BIT])) |=> (div_sel == $past(wb_dat_i[2:0])))
    else $error("divider write delayed");
  full_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((mode == PMC_RUN) && (div_sel == 3'h0)) |-> core_clk_en_o)
    else $error("undivided core clock gated");
  periph_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode != PMC_PDOWN) |-> peripheral_clk_en_o && osc_enable_o)
    else $error("peripheral clock divided or stopped");
  wdog_no_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((mode == PMC_PDOWN) && watchdog_reset_i && !sup_s) |=> (mode == PMC_PDOWN))
    else $error("watchdog ended power-down");
  bus_rest_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
    low_power |-> program_fetch_strobe_n_o && (addr_high_byte_o == 8'hff))
    else $error("fetch strobe or high address not at rest");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  err_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !(hit_pwr | hit_clk | hit_sts)) |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");

endmodule // pmc_power_mode

// [pmc_partner.sv]
// partner model: supervisor, interrupt source and the core-side bus and port drivers
// assumes the bench asks for events by raising the request inputs
`timescale 1ns/1ps
module pmc_partner (
  input wire logic clk_i,
  input wire logic [3:0] req_i,
  output logic irq_any_o,
  output logic sup_reset_o,
  output logic power_on_reset_o,
  output logic watchdog_reset_o,
  output logic [23:0] port_o,
  output logic [7:0] bus_o
);
  // ----------------------------------------
  // events and core-side activity
  // ----------------------------------------
  logic [3:0] ev = 4'h0;
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge clk_i)
  begin
    ev <= req_i;
    cnt <= cnt + 8'h01;
  end
  assign irq_any_o = ev[0];
  assign sup_reset_o = ev[1];
  assign power_on_reset_o = ev[2];
  assign watchdog_reset_o = ev[3];
  // the core side changes every cycle, so a held output is told apart from a live one
  assign port_o = {cnt, ~cnt, cnt ^ 8'h5a};
  assign bus_o = cnt;
endmodule // pmc_partner

// [tb_mcu_power_mode_control.sv]
// testbench for the power-mode controller: register bus, modes, prescaler
// assumes the partner model stands in for supervisor, interrupts and core
`timescale 1ns/1ps
module tb_mcu_power_mode_control;
  import pmc_pkg::*;
  localparam logic [11:0] A_PWR = 12'h21c;
  localparam logic [11:0] A_CLK = 12'h3e4;
  localparam logic [11:0] A_ST = 12'h3e8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [7:0] wdat = 8'h00, lfsr = 8'h61, bus, lo, hi;
  logic [3:0] req = 4'h0, u;
  logic [31:0] rdat, q;
  logic [23:0] pin, pout;
  logic ack, err, e, osc, cen, pen, wen, crst, ale, pfs, rdn, wrn, dbg, irq, sup, pwron, wdog;
  int mismatches = 0, checks_done = 0, cycles = 0;
  pmc_partner pmc_partner_inst (.clk_i(clk_i), .req_i(req), .irq_any_o(irq), .sup_reset_o(sup),
    .power_on_reset_o(pwron), .watchdog_reset_o(wdog), .port_o(pin), .bus_o(bus));
  pmc_power_mode pmc_power_mode_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i({24'h000000, wdat}), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .power_on_reset_i(pwron), .sup_reset_i(sup), .watchdog_reset_i(wdog), .irq_any_i(irq),
    .port_out_i(pin), .ale_i(bus[0]), .program_fetch_strobe_n_i(bus[1]), .rd_n_i(bus[2]), .wr_n_i(bus[3]),
    .muxed_addr_data_low_i(bus), .addr_high_byte_i(~bus), .osc_enable_o(osc), .core_clk_en_o(cen),
    .peripheral_clk_en_o(pen), .watchdog_clk_en_o(wen), .core_reset_o(crst), .port_out_o(pout),
    .ale_o(ale), .program_fetch_strobe_n_o(pfs), .rd_n_o(rdn), .wr_n_o(wrn), .muxed_addr_data_low_o(lo),
    .addr_high_byte_o(hi), .uart0_baud_double_o(u[3]), .uart1_baud_double_o(u[2]),
    .uart1_rx_clock_select_o(u[1]), .uart1_tx_clock_select_o(u[0]), .debug_cmp_enable_o(dbg));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial forever #25 clk_i = ~clk_i;
  function automatic logic [7:0] next_lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int div_of(input logic [2:0] c);
    return (c == 3'd6) ? 1024 : (c == 3'd7) ? 2048 : (1 << c);
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      summarize();
    end
  end
  // classic single cycle: request held until ack or err is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, exp, q);
  endtask
  task automatic mode_is(input logic [1:0] m);
    int k;
    k = 0;
    do
    begin
      wb(1'b0, A_ST, 8'h00);
      k++;
    end
    while (q[1:0] !== m && k < 10);
    chk("mode", {30'h0, m}, q);
  endtask
  task automatic pulse(input int b, input int len);
    req[b] <= 1'b1;
    repeat (len) @(posedge clk_i);
    req[b] <= 1'b0;
  endtask
  task automatic rest(input logic idle_m);
    logic [23:0] held;
    @(negedge clk_i);
    held = pout;
    repeat (5) @(negedge clk_i);
    chk("port_hold", held, pout);
    chk("bus_rest", 20'h7ffff, {ale, pfs, rdn, wrn, lo, hi});
    chk("clk_en", {idle_m, idle_m, 2'b00}, {osc, pen, cen, wen});
  endtask
  task automatic wake();
    int n;
    n = 0;
    pulse(1, 1);
    for (int k = 0; k < 20 && crst !== 1'b1; k++) @(negedge clk_i);
    while (crst === 1'b1 && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("restart_len", 3, n);
    mode_is(PMC_RUN);
    rd(A_PWR, 32'h0, "wake_pwr");
  endtask
  task automatic period(input logic [2:0] c);
    int k;
    wb(1'b1, A_CLK, {5'h00, c});
    for (int i = 0; i < 3; i++)
    begin
      k = 0;
      do
      begin
        @(negedge clk_i);
        k++;
        chk("clk_split", {wen, pen}, {cen, 1'b1});
      end
      while (cen !== 1'b1 && k < 5000);
      if (i == 0)
        chk("div_prompt", 1, k <= div_of(c) + 2);
      else
        chk("div_period", div_of(c), k);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_PWR, 32'h0, "pwr_rst");
    rd(A_CLK, 32'h10, "clk_rst");
    chk("dbg_en", 1, dbg);
    wb(1'b0, 12'h004, 8'h00);
    chk("unmapped_err", 1, e);
    @(negedge clk_i);
    chk("port_pass", pin, pout);
    chk("bus_pass", {bus[0], bus[1], bus[2], bus[3], bus, ~bus}, {ale, pfs, rdn, wrn, lo, hi});
    repeat (6)
    begin
      lfsr = next_lfsr(lfsr);
      wb(1'b1, A_PWR, lfsr & 8'hec);
      rd(A_PWR, {24'h0, lfsr & 8'hcc}, "pwr_fields");
      chk("uart_bits", {lfsr[7:6], lfsr[3:2]}, u);
    end
    for (int c = 7; c >= 0; c--) period(c[2:0]);
    for (int a = 0; a < 2; a++)
    begin
      wb(1'b1, A_CLK, a[0] ? 8'h0b : 8'h03);
      pulse(0, 6);
      rd(A_CLK, a[0] ? 32'h08 : 32'h03, "auto_restore");
    end
    chk("dbg_off", 0, dbg);
    wb(1'b1, A_CLK, 8'h00);
    wb(1'b1, A_PWR, 8'h00);
    wb(1'b1, A_PWR, 8'h01);
    mode_is(PMC_IDLE);
    rest(1'b1);
    pulse(0, 6);
    mode_is(PMC_RUN);
    rd(A_PWR, 32'h0, "idle_clear");
    wb(1'b1, A_PWR, 8'h01);
    mode_is(PMC_IDLE);
    wake();
    wb(1'b1, A_PWR, 8'h03);
    mode_is(PMC_PDOWN);
    rest(1'b0);
    req <= 4'h9;
    repeat (8) @(posedge clk_i);
    req <= 4'h0;
    mode_is(PMC_PDOWN);
    wake();
    pulse(2, 3);
    repeat (8) @(posedge clk_i);
    rd(A_PWR, 32'h10, "cold_set");
    wb(1'b1, A_PWR, 8'h00);
    rd(A_PWR, 32'h0, "cold_clear");
    pulse(1, 3);
    repeat (8) @(posedge clk_i);
    rd(A_PWR, 32'h0, "warm_no_cold");
    summarize();
  end
endmodule // tb_mcu_power_mode_control
